// ### core/pro_predicate_ops.sv
/*
  Predicate register operations unit: initialization, clear, select, moves,
  bitwise logic and flag test, with one cycle of latency.
  Assumes operands come from the predicate register file through the issue
  stage, that results and flags are written back by the caller when the write
  strobes are high, and that the issue stage may send one operation per cycle.
*/
`timescale 1ns/10ps
`include "pro_consts.svh"

module pro_predicate_ops (
  // Clock and reset.
  input wire logic clk_in,
  input wire logic reset_in,
  // Operation issue.
  input wire logic op_valid_in,
  input wire pro_pkg::pro_op_type op_code_in,
  input wire logic [`PRO_ESIZE_BITS-1:0] elem_size_in,
  input wire logic [`PRO_PAT_BITS-1:0] constraint_in,
  // Operands.
  input wire logic [`PRO_PRED_BITS-1:0] gov_in,
  input wire logic [`PRO_PRED_BITS-1:0] src_a_in,
  input wire logic [`PRO_PRED_BITS-1:0] src_b_in,
  input wire logic [`PRO_PRED_BITS-1:0] dest_old_in,
  // Results.
  output logic done_out,
  output logic pred_write_out,
  output logic [`PRO_PRED_BITS-1:0] pred_result_out,
  output logic flags_write_out,
  output logic [3:0] flags_out,
  output logic [`PRO_COUNT_BITS-1:0] elem_count_out
);

  // --------------------------------------------------------------------------
  // Helper functions
  // --------------------------------------------------------------------------

  // Element bound for a named constraint and element size; zero when invalid.
  function automatic logic [`PRO_COUNT_BITS-1:0] constraint_bound(
    input logic [`PRO_PAT_BITS-1:0] pat,
    input logic [`PRO_ESIZE_BITS-1:0] es
  );
    logic [`PRO_COUNT_BITS-1:0] avail;
    logic [`PRO_COUNT_BITS-1:0] fixed;
    logic [`PRO_COUNT_BITS-1:0] largest_power_of_two_count;
    logic [`PRO_COUNT_BITS-1:0] bound;
    avail = `PRO_COUNT_BITS'(`PRO_PRED_BITS >> es);
    fixed = '0;
    largest_power_of_two_count = '0;
    bound = '0;
    // Largest power of two not above the available count.
    for (int b = 0; b < `PRO_COUNT_BITS; b++) begin
      if (avail[b]) begin
        largest_power_of_two_count = `PRO_COUNT_BITS'(1 << b);
      end
    end
    if (pat >= `PRO_PAT_FIXED_COUNT_ONE && pat <= `PRO_PAT_FIXED_SMALL_LAST) begin
      fixed = {4'h0, pat};
    end else if (pat >= `PRO_PAT_FIXED_LARGE_FIRST && pat <= `PRO_PAT_FIXED_COUNT_MAX) begin
      fixed = `PRO_FIXED_LARGE_BASE << (pat - `PRO_PAT_FIXED_LARGE_FIRST);
    end
    // Fixed counts are decoded first, so the default branch can also judge
    // whether a fixed request is longer than the vector for this size.
    case (pat)
      `PRO_PAT_LARGEST_POWER_OF_TWO_COUNT: begin
        bound = largest_power_of_two_count;
      end
      `PRO_PAT_LARGEST_MULTIPLE_FOUR_COUNT: begin
        bound = avail - (avail % `PRO_COUNT_BITS'(4));
      end
      `PRO_PAT_LARGEST_MULTIPLE_THREE_COUNT: begin
        bound = avail - (avail % `PRO_COUNT_BITS'(3));
      end
      `PRO_PAT_ALL: begin
        bound = avail;
      end
      default: begin
        // A fixed count that exceeds the vector, or an unused code, gives zero.
        bound = (fixed > avail) ? '0 : fixed;
      end
    endcase
    return bound;
  endfunction : constraint_bound

  // Predicate with the leading bit of each element below the bound set.
  function automatic logic [`PRO_PRED_BITS-1:0] bound_mask(
    input logic [`PRO_COUNT_BITS-1:0] bound,
    input logic [`PRO_ESIZE_BITS-1:0] es
  );
    logic [`PRO_PRED_BITS-1:0] m;
    logic [`PRO_COUNT_BITS-1:0] pos;
    logic [`PRO_COUNT_BITS-1:0] stride_mask;
    m = '0;
    pos = '0;
    stride_mask = (`PRO_COUNT_BITS'(1) << es) - `PRO_COUNT_BITS'(1);
    for (int i = 0; i < `PRO_PRED_BITS; i++) begin
      pos = `PRO_COUNT_BITS'(i);
      m[i] = ((pos & stride_mask) == '0) && ((pos >> es) < bound);
    end
    return m;
  endfunction : bound_mask

  // Condition flags of a result under a governing predicate of 1-bit elements.
  function automatic logic [3:0] derive_flags(
    input logic [`PRO_PRED_BITS-1:0] res,
    input logic [`PRO_PRED_BITS-1:0] gov
  );
    logic [3:0] f;
    logic first_val;
    logic last_val;
    // Start from the no-active-element outcome. Each scan below is a plain
    // priority chain, which trades some logic depth for readability.
    f = `PRO_FLAGS_NONE_ACTIVE;
    first_val = 1'b0;
    last_val = 1'b0;
    // Scanning from the top leaves the lowest active bit as the first element.
    for (int i = `PRO_PRED_BITS - 1; i >= 0; i--) begin
      if (gov[i]) begin
        first_val = res[i];
      end
    end
    // Scanning from the bottom leaves the highest active bit as the last element.
    for (int i = 0; i < `PRO_PRED_BITS; i++) begin
      if (gov[i]) begin
        last_val = res[i];
      end
    end
    if (gov != '0) begin
      f[`PRO_FLAG_N] = first_val;
      f[`PRO_FLAG_C] = ~last_val;
    end
    f[`PRO_FLAG_Z] = ((res & gov) == '0);
    f[`PRO_FLAG_V] = 1'b0;
    return f;
  endfunction : derive_flags

  // --------------------------------------------------------------------------
  // Operation decode and datapath
  // --------------------------------------------------------------------------
  logic [`PRO_COUNT_BITS-1:0] bound_nxt;
  logic [`PRO_PRED_BITS-1:0] init_mask;
  logic [`PRO_PRED_BITS-1:0] elem_gov;
  logic [`PRO_PRED_BITS-1:0] result_nxt;
  logic [`PRO_PRED_BITS-1:0] flag_gov;
  logic [`PRO_PRED_BITS-1:0] flag_value;
  logic [`PRO_COUNT_BITS-1:0] count_nxt;
  logic write_nxt;
  logic set_flags_nxt;

  // Constraint bound and the masks built from it for the current element size.
  assign bound_nxt = constraint_bound(constraint_in, elem_size_in);
  assign init_mask = bound_mask(bound_nxt, elem_size_in);
  assign elem_gov = bound_mask(`PRO_COUNT_BITS'(`PRO_PRED_BITS), elem_size_in);

  // Two cases select the result, write strobes and flag inputs. Logic ops use
  // gov_in as 1-bit elements; a non-canonical gov_in is the issuer's fault.
  always_comb begin
    result_nxt = '0;
    flag_gov = gov_in;
    flag_value = '0;
    count_nxt = '0;
    write_nxt = 1'b0;
    set_flags_nxt = 1'b0;
    case (op_code_in)
      pro_pkg::PRO_OP_PREDICATE_CLEAR_ALL: begin
        result_nxt = '0;
        write_nxt = 1'b1;
      end
      pro_pkg::PRO_OP_PREDICATE_INIT_FROM_CONSTRAINT: begin
        result_nxt = init_mask;
        count_nxt = bound_nxt;
        write_nxt = 1'b1;
      end
      pro_pkg::PRO_OP_PREDICATE_INIT_FROM_CONSTRAINT_FLAGS: begin
        // Flags judge the new predicate over all elements of this size.
        result_nxt = init_mask;
        count_nxt = bound_nxt;
        write_nxt = 1'b1;
        set_flags_nxt = 1'b1;
        flag_gov = elem_gov;
        flag_value = init_mask;
      end
      pro_pkg::PRO_OP_PREDICATE_SELECT: begin
        result_nxt = (src_a_in & gov_in) | (src_b_in & ~gov_in);
        write_nxt = 1'b1;
      end
      pro_pkg::PRO_OP_PREDICATE_MOVE_MERGE: begin
        result_nxt = (src_a_in & gov_in) | (dest_old_in & ~gov_in);
        write_nxt = 1'b1;
      end
      pro_pkg::PRO_OP_PREDICATE_MOVE_ZERO: begin
        result_nxt = src_a_in & gov_in;
        write_nxt = 1'b1;
      end
      pro_pkg::PRO_OP_PREDICATE_MOVE: begin
        result_nxt = src_a_in;
        write_nxt = 1'b1;
      end
      pro_pkg::PRO_OP_PREDICATE_MOVE_ZERO_FLAGS: begin
        result_nxt = src_a_in & gov_in;
        write_nxt = 1'b1;
        set_flags_nxt = 1'b1;
        flag_value = src_a_in & gov_in;
      end
      pro_pkg::PRO_OP_PREDICATE_MOVE_FLAGS: begin
        // With no governing operand the source governs its own flags.
        result_nxt = src_a_in;
        write_nxt = 1'b1;
        set_flags_nxt = 1'b1;
        flag_gov = src_a_in;
        flag_value = src_a_in;
      end
      pro_pkg::PRO_OP_PREDICATE_AND,
      pro_pkg::PRO_OP_PREDICATE_AND_FLAGS: begin
        result_nxt = src_a_in & src_b_in & gov_in;
        write_nxt = 1'b1;
      end
      pro_pkg::PRO_OP_PREDICATE_AND_NOT,
      pro_pkg::PRO_OP_PREDICATE_AND_NOT_FLAGS: begin
        result_nxt = src_a_in & ~src_b_in & gov_in;
        write_nxt = 1'b1;
      end
      pro_pkg::PRO_OP_PREDICATE_XOR,
      pro_pkg::PRO_OP_PREDICATE_XOR_FLAGS: begin
        result_nxt = (src_a_in ^ src_b_in) & gov_in;
        write_nxt = 1'b1;
      end
      pro_pkg::PRO_OP_PREDICATE_NAND,
      pro_pkg::PRO_OP_PREDICATE_NAND_FLAGS: begin
        result_nxt = ~(src_a_in & src_b_in) & gov_in;
        write_nxt = 1'b1;
      end
      pro_pkg::PRO_OP_PREDICATE_NOR,
      pro_pkg::PRO_OP_PREDICATE_NOR_FLAGS: begin
        result_nxt = ~(src_a_in | src_b_in) & gov_in;
        write_nxt = 1'b1;
      end
      pro_pkg::PRO_OP_PREDICATE_INVERT,
      pro_pkg::PRO_OP_PREDICATE_INVERT_FLAGS: begin
        result_nxt = ~src_a_in & gov_in;
        write_nxt = 1'b1;
      end
      pro_pkg::PRO_OP_PREDICATE_OR_NOT,
      pro_pkg::PRO_OP_PREDICATE_OR_NOT_FLAGS: begin
        result_nxt = (src_a_in | ~src_b_in) & gov_in;
        write_nxt = 1'b1;
      end
      pro_pkg::PRO_OP_PREDICATE_OR,
      pro_pkg::PRO_OP_PREDICATE_OR_FLAGS: begin
        result_nxt = (src_a_in | src_b_in) & gov_in;
        write_nxt = 1'b1;
      end
      pro_pkg::PRO_OP_PREDICATE_FLAG_TEST: begin
        // Nothing is written back; only the flags move.
        set_flags_nxt = 1'b1;
        flag_value = src_a_in;
      end
      default: begin
        result_nxt = '0;
      end
    endcase
    // The flag-setting logic variants judge their own masked result.
    case (op_code_in)
      pro_pkg::PRO_OP_PREDICATE_AND_FLAGS,
      pro_pkg::PRO_OP_PREDICATE_AND_NOT_FLAGS,
      pro_pkg::PRO_OP_PREDICATE_XOR_FLAGS,
      pro_pkg::PRO_OP_PREDICATE_NAND_FLAGS,
      pro_pkg::PRO_OP_PREDICATE_NOR_FLAGS,
      pro_pkg::PRO_OP_PREDICATE_INVERT_FLAGS,
      pro_pkg::PRO_OP_PREDICATE_OR_NOT_FLAGS,
      pro_pkg::PRO_OP_PREDICATE_OR_FLAGS: begin
        set_flags_nxt = 1'b1;
        flag_value = result_nxt;
      end
      default: begin
        flag_value = flag_value;
      end
    endcase
  end

  // Masking with gov_in in every logic form keeps inactive bits at zero and
  // treats each bit alone, whatever element size the issuer also sends.
  // The logic forms never read elem_size_in, so any size qualifier from the
  // issuer leaves the result unchanged. A governing bit that is clear always
  // yields a zero result bit, and the flag test writes no destination at all.
  // Reading only gov_in here keeps the logic path short.

  // --------------------------------------------------------------------------
  // Output registers
  // --------------------------------------------------------------------------
  logic done_r;
  logic pred_write_r;
  logic [`PRO_PRED_BITS-1:0] pred_result_r;
  logic flags_write_r;
  logic [3:0] flags_r;
  logic [`PRO_COUNT_BITS-1:0] elem_count_r;

  // Every output is a flip-flop, so a consumer sees clean values a cycle
  // after issue; the cost is one cycle of latency on every operation.
  // Completion and write strobes are one-cycle pulses per accepted operation.
  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      done_r <= 1'b0;
      pred_write_r <= 1'b0;
      flags_write_r <= 1'b0;
    end else begin
      done_r <= op_valid_in && (op_code_in != pro_pkg::PRO_OP_NONE);
      pred_write_r <= op_valid_in && write_nxt;
      flags_write_r <= op_valid_in && set_flags_nxt;
    end
  end

  // The result and count hold their last value between operations.
  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      pred_result_r <= `PRO_PRED_RESET;
      elem_count_r <= '0;
    end else if (op_valid_in && write_nxt) begin
      pred_result_r <= result_nxt;
      elem_count_r <= count_nxt;
    end
  end

  // Flags change only on flag-setting operations, so a consumer may read
  // them at any time and see the last flag-setting outcome.
  // A limitation: the flags can be preset only by issuing a flag operation.
  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      flags_r <= `PRO_FLAGS_RESET;
    end else if (op_valid_in && set_flags_nxt) begin
      flags_r <= derive_flags(flag_value, flag_gov);
    end
  end

  // Outputs straight from the registers.
  // No output passes through logic after its flip-flop.
  assign done_out = done_r;
  assign pred_write_out = pred_write_r;
  assign pred_result_out = pred_result_r;
  assign flags_write_out = flags_write_r;
  assign flags_out = flags_r;
  assign elem_count_out = elem_count_r;

endmodule : pro_predicate_ops

// ### core/pro_consts.svh
/*
  Constants of the predicate register operations unit: predicate and field
  widths, named constraint codes, condition flag positions and reset values.
  Assumes it is included by its bare name from the design file and the testbench files.
*/
// Notes on behaviour
// - Initialization clears all elements, or sets those below the constraint bound.
// - Fixed constraints give bounds from one to two hundred fifty-six elements.
// - Power-of-two constraint bounds at largest power of two within available.
// - Multiple constraints bound at largest multiple of three or four within available.
// - The all constraint selects every accessible element, always an even count.
// - Unknown or too-large constraints give all false, with no exception.
// - Clear writes false to every destination element whatever the element size.
// - Flag-setting initialization writes the predicate and updates the flags.
// - Select takes first source where governing is true, else the second.
// - Predicated move copies active elements; inactive ones merge or zero.
// - Unpredicated move copies every source bit unconditionally.
// - Flag-setting moves copy and then update flags from the result.
// - Logic acts on every bit as its own element, ignoring element size.
// - Flag-setting logic sets negative, zero, carry from result; overflow cleared.
// - Logic results are zero where governing is false; test writes nothing.
// - Logic offers and, and-not, xor, nand, nor, invert, or-not, or, with flags.
// - Test updates only the flags from a value under a governing predicate.
`ifndef PRO_CONSTS_SVH
`define PRO_CONSTS_SVH

// ----------------------------------------------------------------------------
// Widths
// ----------------------------------------------------------------------------
`define PRO_PRED_BITS 256
`define PRO_COUNT_BITS 9
`define PRO_PAT_BITS 5
`define PRO_ESIZE_BITS 2

// ----------------------------------------------------------------------------
// Named constraint codes
// ----------------------------------------------------------------------------
`define PRO_PAT_LARGEST_POWER_OF_TWO_COUNT 5'h00
`define PRO_PAT_FIXED_COUNT_ONE 5'h01
`define PRO_PAT_FIXED_SMALL_LAST 5'h08
`define PRO_PAT_FIXED_LARGE_FIRST 5'h09
`define PRO_PAT_FIXED_COUNT_MAX 5'h0D
`define PRO_PAT_LARGEST_MULTIPLE_FOUR_COUNT 5'h1D
`define PRO_PAT_LARGEST_MULTIPLE_THREE_COUNT 5'h1E
`define PRO_PAT_ALL 5'h1F
`define PRO_FIXED_LARGE_BASE 9'h010

// ----------------------------------------------------------------------------
// Condition flags and reset values
// ----------------------------------------------------------------------------
`define PRO_FLAG_N 3
`define PRO_FLAG_Z 2
`define PRO_FLAG_C 1
`define PRO_FLAG_V 0
`define PRO_FLAGS_RESET 4'h0
`define PRO_FLAGS_NONE_ACTIVE 4'h6
`define PRO_PRED_RESET 256'h0

`endif

// ### core/pro_pkg.sv
/*
  Types of the predicate register operations unit: the operation code set.
  Assumes the decode stage encodes its operations with this enumeration.
*/
package pro_pkg;

  // --------------------------------------------------------------------------
  // Operation codes
  // --------------------------------------------------------------------------
  typedef enum logic [4:0] {
    PRO_OP_NONE,
    PRO_OP_PREDICATE_CLEAR_ALL,
    PRO_OP_PREDICATE_INIT_FROM_CONSTRAINT,
    PRO_OP_PREDICATE_INIT_FROM_CONSTRAINT_FLAGS,
    PRO_OP_PREDICATE_SELECT,
    PRO_OP_PREDICATE_MOVE_MERGE,
    PRO_OP_PREDICATE_MOVE_ZERO,
    PRO_OP_PREDICATE_MOVE,
    PRO_OP_PREDICATE_MOVE_ZERO_FLAGS,
    PRO_OP_PREDICATE_MOVE_FLAGS,
    PRO_OP_PREDICATE_AND,
    PRO_OP_PREDICATE_AND_FLAGS,
    PRO_OP_PREDICATE_AND_NOT,
    PRO_OP_PREDICATE_AND_NOT_FLAGS,
    PRO_OP_PREDICATE_XOR,
    PRO_OP_PREDICATE_XOR_FLAGS,
    PRO_OP_PREDICATE_NAND,
    PRO_OP_PREDICATE_NAND_FLAGS,
    PRO_OP_PREDICATE_NOR,
    PRO_OP_PREDICATE_NOR_FLAGS,
    PRO_OP_PREDICATE_INVERT,
    PRO_OP_PREDICATE_INVERT_FLAGS,
    PRO_OP_PREDICATE_OR_NOT,
    PRO_OP_PREDICATE_OR_NOT_FLAGS,
    PRO_OP_PREDICATE_OR,
    PRO_OP_PREDICATE_OR_FLAGS,
    PRO_OP_PREDICATE_FLAG_TEST
  } pro_op_type;

endpackage : pro_pkg

// ### tb/pro_predicate_ops_monitor.sv
/*
  Checker for the predicate operations unit, watching only its ports.
  Assumes one cycle of latency and results that hold between updates.
*/
`timescale 1ns/10ps
`include "pro_consts.svh"

module pro_predicate_ops_monitor (
  // Clock and reset.
  input wire logic clk_in,
  input wire logic reset_in,
  // Operation issue.
  input wire logic op_valid_in,
  input wire pro_pkg::pro_op_type op_code_in,
  input wire logic [`PRO_ESIZE_BITS-1:0] elem_size_in,
  input wire logic [`PRO_PAT_BITS-1:0] constraint_in,
  // Operands.
  input wire logic [`PRO_PRED_BITS-1:0] gov_in,
  input wire logic [`PRO_PRED_BITS-1:0] src_a_in,
  input wire logic [`PRO_PRED_BITS-1:0] src_b_in,
  input wire logic [`PRO_PRED_BITS-1:0] dest_old_in,
  // Results.
  input wire logic done_out,
  input wire logic pred_write_out,
  input wire logic [`PRO_PRED_BITS-1:0] pred_result_out,
  input wire logic flags_write_out,
  input wire logic [3:0] flags_out,
  input wire logic [`PRO_COUNT_BITS-1:0] elem_count_out
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (reset_in);

  // A real operation is a valid strobe with anything but the idle code.
  logic go;
  assign go = op_valid_in && (op_code_in != pro_pkg::PRO_OP_NONE);

  // ----------------------------------------------------------------------
  // Timing and holding
  // ----------------------------------------------------------------------
  a_done_follows: assert property (
    go |=> done_out) else $error("Operation gave no completion pulse.");
  a_no_stray_strobe: assert property (
    !go |=> !done_out && !pred_write_out && !flags_write_out)
    else $error("Strobe without an operation.");
  a_result_holds: assert property (
    !pred_write_out |-> $stable(pred_result_out)) else $error("Result moved unwritten.");
  a_flags_hold: assert property (
    !flags_write_out |-> $stable(flags_out)) else $error("Flags moved unwritten.");
  // ----------------------------------------------------------------------
  // Values
  // ----------------------------------------------------------------------
  a_overflow_clear: assert property (
    flags_write_out |-> !flags_out[`PRO_FLAG_V]) else $error("Overflow flag set.");
  a_test_no_write: assert property (
    go && op_code_in == pro_pkg::PRO_OP_PREDICATE_FLAG_TEST
    |=> flags_write_out && !pred_write_out) else $error("Test wrote a predicate.");
  a_clear_all_zero: assert property (
    go && op_code_in == pro_pkg::PRO_OP_PREDICATE_CLEAR_ALL
    |=> pred_write_out && pred_result_out == `PRO_PRED_RESET) else $error("Clear not zero.");
  a_none_active: assert property (
    go && op_code_in == pro_pkg::PRO_OP_PREDICATE_FLAG_TEST && gov_in == `PRO_PRED_RESET
    |=> flags_out == `PRO_FLAGS_NONE_ACTIVE) else $error("Empty governing gave wrong flags.");
  a_unknown_pattern: assert property (
    go && op_code_in == pro_pkg::PRO_OP_PREDICATE_INIT_FROM_CONSTRAINT
    && constraint_in inside {[5'h0E:5'h1C]}
    |=> pred_result_out == `PRO_PRED_RESET && elem_count_out == 9'h000)
    else $error("Unspecified constraint set elements.");
  a_count_bound: assert property (
    elem_count_out <= 9'h100) else $error("Element count above maximum.");

  // Main scenarios that must be reached.
  c_init_flags: cover property (go
    && op_code_in == pro_pkg::PRO_OP_PREDICATE_INIT_FROM_CONSTRAINT_FLAGS);
  c_flag_test: cover property (go && op_code_in == pro_pkg::PRO_OP_PREDICATE_FLAG_TEST);
  c_back_to_back: cover property (go ##1 go);
endmodule : pro_predicate_ops_monitor

bind pro_predicate_ops pro_predicate_ops_monitor u_mon (
  .clk_in(clk_in), .reset_in(reset_in), .op_valid_in(op_valid_in),
  .op_code_in(op_code_in), .elem_size_in(elem_size_in), .constraint_in(constraint_in),
  .gov_in(gov_in), .src_a_in(src_a_in), .src_b_in(src_b_in), .dest_old_in(dest_old_in),
  .done_out(done_out), .pred_write_out(pred_write_out), .pred_result_out(pred_result_out),
  .flags_write_out(flags_write_out), .flags_out(flags_out), .elem_count_out(elem_count_out)
);

// ### tb/pro_issue_model.sv
/*
  Issue-stage model: presents one operation and its operands to the unit.
  Assumes its caller invokes send just after a falling clock edge.
*/
`timescale 1ns/10ps
`include "pro_consts.svh"

module pro_issue_model (
  // Operation issue.
  output logic op_valid_out,
  output pro_pkg::pro_op_type op_code_out,
  output logic [`PRO_ESIZE_BITS-1:0] elem_size_out,
  output logic [`PRO_PAT_BITS-1:0] constraint_out,
  // Operands.
  output logic [`PRO_PRED_BITS-1:0] gov_out,
  output logic [`PRO_PRED_BITS-1:0] src_a_out,
  output logic [`PRO_PRED_BITS-1:0] src_b_out,
  output logic [`PRO_PRED_BITS-1:0] dest_old_out
);
  // Idle at time zero so the unit never sees unknown inputs.
  initial begin
    op_valid_out = 1'b0;
    op_code_out = pro_pkg::PRO_OP_NONE;
    {elem_size_out, constraint_out} = 7'h00;
    {gov_out, src_a_out, src_b_out, dest_old_out} = {4{`PRO_PRED_RESET}};
  end

  // One-bit elements make every governing mask canonical, so it passes whole.
  task automatic send(input logic v, input pro_pkg::pro_op_type op, input logic [1:0] es,
                      input logic [4:0] c, input logic [255:0] g, a, b, old);
    op_valid_out = v;
    op_code_out = op;
    elem_size_out = es;
    constraint_out = c;
    gov_out = g;
    {src_a_out, src_b_out, dest_old_out} = {a, b, old};
  endtask : send
endmodule : pro_issue_model

// ### tb/test_predicate_register_ops_unit.sv
/*
  Self-checking bench of the predicate operations unit with a queue model.
  Assumes the issue model drives at the falling edge and latency is one cycle.
*/
`timescale 1ns/10ps
`include "pro_consts.svh"

module test_predicate_register_ops_unit;
  typedef struct {
    logic dn;
    logic pw;
    logic fw;
    logic [255:0] r;
    logic [3:0] f;
    logic [8:0] c;
  } pro_exp_type;
  logic clk_in = 1'b0;
  logic reset_in = 1'b1;
  logic op_valid, done, pred_write, flags_write;
  pro_pkg::pro_op_type op_code;
  logic [1:0] elem_size;
  logic [4:0] pat;
  logic [255:0] gov, src_a, src_b, dest_old, pred_result, gsel;
  logic [3:0] flags;
  logic [8:0] elem_count;
  int errors = 0;
  int cmp_count = 0;
  pro_exp_type pend[$];
  pro_exp_type st;

  // Free-running 100 MHz clock.
  always #5 clk_in = ~clk_in;

  pro_issue_model drv (.op_valid_out(op_valid), .op_code_out(op_code),
    .elem_size_out(elem_size), .constraint_out(pat), .gov_out(gov), .src_a_out(src_a),
    .src_b_out(src_b), .dest_old_out(dest_old));
  pro_predicate_ops dut (.clk_in(clk_in), .reset_in(reset_in), .op_valid_in(op_valid),
    .op_code_in(op_code), .elem_size_in(elem_size), .constraint_in(pat), .gov_in(gov),
    .src_a_in(src_a), .src_b_in(src_b), .dest_old_in(dest_old), .done_out(done),
    .pred_write_out(pred_write), .pred_result_out(pred_result),
    .flags_write_out(flags_write), .flags_out(flags), .elem_count_out(elem_count));

  // --------------------------------------------------------------------------
  // Reference model
  // --------------------------------------------------------------------------
  // Flags from the lowest and highest governed bits; no active bit gives Z and C.
  function automatic logic [3:0] flg(logic [255:0] v, logic [255:0] g);
    int lo = -1;
    int hi = -1;
    for (int i = 0; i < 256; i++) if (g[i]) begin
      if (lo < 0) lo = i;
      hi = i;
    end
    if (lo < 0) return 4'h6;
    return {v[lo], (v & g) == 256'h0, !v[hi], 1'b0};
  endfunction : flg

  // Element bound of a named constraint; a bound past the vector yields none.
  function automatic int bnd(int c, int es);
    int av = 256 >> es;
    int n = 1;
    while (n * 2 <= av) n = n * 2;
    if (c == 0) n = n;
    else if (c <= 8) n = c;
    else if (c <= 13) n = 16 << (c - 9);
    else if (c == 29) n = av / 4 * 4;
    else if (c == 30) n = av / 3 * 3;
    else if (c == 31) n = av;
    else n = 0;
    return (n > av) ? 0 : n;
  endfunction : bnd

  function automatic logic [255:0] rnd();
    logic [255:0] v;
    for (int i = 0; i < 8; i++) v[i*32 +: 32] = $urandom;
    return v;
  endfunction : rnd

  task automatic chk(string nm, logic [255:0] e, logic [255:0] s);
    cmp_count++;
    if (e !== s) begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", nm, e, s);
    end
  endtask : chk

  // Check the previous cycle's outcome, then issue the next operation.
  task automatic step(logic v, int o, int es, int c, logic [255:0] g, a, b, old);
    pro_exp_type e;
    logic [255:0] lg [8];
    logic [255:0] lead;
    int n;
    @(negedge clk_in);
    if (pend.size() > 0) begin
      e = pend.pop_front();
      chk("done", e.dn, done);
      chk("pred_write", e.pw, pred_write);
      chk("flags_write", e.fw, flags_write);
      chk("result", e.r, pred_result);
      chk("flags", e.f, flags);
      chk("count", e.c, elem_count);
    end
    e = st;
    {e.dn, e.pw, e.fw} = 3'h0;
    n = bnd(c, es);
    lead = 256'h0;
    for (int i = 0; i < (256 >> es); i++) lead[i << es] = 1'b1;
    lg = '{a & b, a & ~b, a ^ b, ~(a & b), ~(a | b), ~a, a | ~b, a | b};
    if (v && o != 0) begin
      e.dn = 1'b1;
      e.pw = (o != 26);
      e.fw = (o == 3) || (o == 8) || (o == 9) || (o >= 10 && (o % 2 == 1 || o == 26));
      if (o != 26) e.c = 9'h000;
      if (o == 1) e.r = 256'h0;
      else if (o <= 3) begin
        e.c = n[8:0];
        e.r = 256'h0;
        for (int i = 0; i < n; i++) e.r[i << es] = 1'b1;
      end
      else if (o == 4) e.r = a & g | b & ~g;
      else if (o == 5) e.r = a & g | old & ~g;
      else if (o == 6 || o == 8) e.r = a & g;
      else if (o == 7 || o == 9) e.r = a;
      else if (o <= 25) e.r = lg[(o - 10) / 2] & g;
      if (e.fw) e.f = flg((o == 26) ? a : e.r, (o == 3) ? lead : (o == 9) ? a : g);
    end
    pend.push_back(e);
    st = e;
    drv.send(v, pro_pkg::pro_op_type'(o[4:0]), es[1:0], c[4:0], g, a, b, old);
  endtask : step

  // Reset for some cycles; every output must read zero before release.
  task automatic do_reset(int cyc);
    reset_in = 1'b1;
    repeat (cyc) @(negedge clk_in);
    // Idle the issue port so no stale operation is taken at release.
    drv.send(1'b0, pro_pkg::PRO_OP_NONE, 2'h0, 5'h00, 256'h0, 256'h0, 256'h0, 256'h0);
    chk("reset_result", 256'h0, pred_result);
    chk("reset_ctl", 256'h0, {240'h0, done, pred_write, flags_write, flags, elem_count});
    reset_in = 1'b0;
    pend.delete();
    st = '{default: '0};
  endtask : do_reset

  task automatic wrap_up();
    if (errors == 0 && cmp_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : wrap_up

  // --------------------------------------------------------------------------
  // Scenarios
  // --------------------------------------------------------------------------
  // Every constraint code at every size, back to back, then random traffic.
  initial begin
    void'($urandom(83));
    do_reset(16);
    for (int es = 0; es < 4; es++) begin
      for (int c = 0; c < 32; c++) begin
        step(1'b1, 2, es, c, rnd(), rnd(), rnd(), rnd());
        step(1'b1, 3, es, c, rnd(), rnd(), rnd(), rnd());
      end
    end
    for (int k = 0; k < 270; k++) begin
      if (k == 135) do_reset(2);
      gsel = (k % 5 == 0) ? 256'h0 : (k % 5 == 1) ? (256'h1 << $urandom_range(255)) : rnd();
      if (k % 5 == 2) gsel = ~256'h0;
      step($urandom_range(7) != 0, k % 27, $urandom_range(3), $urandom_range(31), gsel,
           rnd(), rnd(), rnd());
    end
    step(1'b0, 0, 0, 0, 256'h0, 256'h0, 256'h0, 256'h0);
    wrap_up();
  end

  // Watchdog well beyond the roughly five hundred fifty cycles of the scenarios.
  initial begin
    #20000;
    errors++;
    wrap_up();
  end
endmodule : test_predicate_register_ops_unit
